/* src/tuner_link_pkg.sv */
package tuner_link_pkg;

	// ----------------------------------------
	// Word layout
	// ----------------------------------------
	localparam int WORD_BITS        = 8;
	localparam int CAP_BITS         = 5;
	localparam int HOLD_BIT_POS     = 5;
	localparam int CAP_MSB_POS      = 4;
	localparam int CAP_LSB_POS      = 0;
	localparam int TOP_ZERO_MSB     = 7;
	localparam int TOP_ZERO_LSB     = 6;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] WORD_RESET = 8'h00;
	localparam logic [4:0] CAP_RESET  = 5'h00;

	// ----------------------------------------
	// Timing (core clock 40 MHz)
	// ----------------------------------------
	localparam real CORE_PERIOD_NS   = 25.0;
	localparam real SEL_LOW_MIN_NS   = 38.4;
	localparam real SEL_SETUP_MIN_NS = 19.2;
	localparam real WAKE_MAX_US      = 20.0;
	localparam int  SEL_LOW_CYC      = (SEL_LOW_MIN_NS / CORE_PERIOD_NS) > 1.0 ?
		int'($ceil(SEL_LOW_MIN_NS / CORE_PERIOD_NS)) : 1;
	localparam int  SEL_SETUP_CYC    = (SEL_SETUP_MIN_NS / CORE_PERIOD_NS) > 1.0 ?
		int'($ceil(SEL_SETUP_MIN_NS / CORE_PERIOD_NS)) : 1;
	localparam int  WAKE_CYC         = int'($ceil(WAKE_MAX_US * 1000.0 / CORE_PERIOD_NS));
	localparam int  LINK_HALF_CYC    = 4;

	// ----------------------------------------
	// Master command registers
	// ----------------------------------------
	localparam logic [1:0] ADDR_CTRL   = 2'h0;
	localparam logic [1:0] ADDR_WORD   = 2'h1;
	localparam logic [1:0] ADDR_STATUS = 2'h2;
	localparam int  CTRL_GO_POS        = 0;
	localparam int  ST_BUSY_POS        = 0;
	localparam int  ST_WAKE_POS        = 1;

endpackage

/* src/tuner_link_if.sv */
`timescale 1ns/1ps
interface tuner_link_if;
	logic tuner_select;
	logic shift_clk;
	logic shift_data_pin;

	modport master (
		output tuner_select,
		output shift_clk,
		output shift_data_pin
	);
	modport tuner (
		input  tuner_select,
		input  shift_clk,
		input  shift_data_pin
	);
endinterface

/* src/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync
	import tuner_link_pkg::*;
#(
	parameter int WIDTH = 3
) (
	input  wire logic             core_clk_in,
	input  wire logic             arst_n_in,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] nxt_sync;

	// Two flops per pin; first stage feeds only the second
	always_comb begin
		nxt_meta = pin_in;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign sync_out = sync_ff;
endmodule

/* src/tuner_port.sv */
`timescale 1ns/1ps
module tuner_port
	import tuner_link_pkg::*;
(
	input  wire logic                core_clk_in,
	input  wire logic                arst_n_in,
	tuner_link_if.tuner              link,
	output logic                     low_power_hold_out,
	output logic [CAP_BITS-1:0]      cap_state_out,
	output logic                     update_out
);
	// ----------------------------------------
	// Pin sampling
	// ----------------------------------------
	logic [2:0] pins_sync;
	logic       sel_s;
	logic       clk_s;
	logic       dat_s;

	pin_sync #(.WIDTH(3)) u_sync (
		.core_clk_in (core_clk_in),
		.arst_n_in   (arst_n_in),
		.pin_in      ({link.tuner_select, link.shift_clk, link.shift_data_pin}),
		.sync_out    (pins_sync)
	);
	assign {sel_s, clk_s, dat_s} = pins_sync;

	// ----------------------------------------
	// Shift and activate
	// ----------------------------------------
	logic [WORD_BITS-1:0] shift_ff;
	logic [WORD_BITS-1:0] nxt_shift;
	logic                 sel_d_ff;
	logic                 nxt_sel_d;
	logic                 clk_d_ff;
	logic                 nxt_clk_d;
	logic                 hold_ff;
	logic                 nxt_hold;
	logic [CAP_BITS-1:0]  cap_ff;
	logic [CAP_BITS-1:0]  nxt_cap;
	logic                 upd_ff;
	logic                 nxt_upd;

	// Edge detect on synchronised copies, shift, load on select fall
	always_comb begin
		nxt_sel_d = sel_s;
		nxt_clk_d = clk_s;
		nxt_shift = shift_ff;
		nxt_hold  = hold_ff;
		nxt_cap   = cap_ff;
		nxt_upd   = 1'b0;
		if (sel_s && clk_s && !clk_d_ff) begin
			nxt_shift = {shift_ff[WORD_BITS-2:0], dat_s};
		end
		if (!sel_s && sel_d_ff) begin
			nxt_hold = shift_ff[HOLD_BIT_POS];
			nxt_cap  = shift_ff[CAP_MSB_POS:CAP_LSB_POS];
			nxt_upd  = 1'b1;
		end
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			shift_ff <= WORD_RESET;
			sel_d_ff <= 1'b0;
			clk_d_ff <= 1'b0;
			hold_ff  <= 1'b0;
			cap_ff   <= CAP_RESET;
			upd_ff   <= 1'b0;
		end else begin
			shift_ff <= nxt_shift;
			sel_d_ff <= nxt_sel_d;
			clk_d_ff <= nxt_clk_d;
			hold_ff  <= nxt_hold;
			cap_ff   <= nxt_cap;
			upd_ff   <= nxt_upd;
		end
	end

	// Outputs straight from flops; nothing goes back on the link
	assign low_power_hold_out = hold_ff;
	assign cap_state_out      = cap_ff;
	assign update_out         = upd_ff;
endmodule

/* src/tuner_master.sv */
`timescale 1ns/1ps
module tuner_master
	import tuner_link_pkg::*;
#(
	parameter int HALF_CYC = LINK_HALF_CYC,
	parameter int WAKE_CNT = WAKE_CYC
) (
	input  wire logic       core_clk_in,
	input  wire logic       arst_n_in,
	input  wire logic [1:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic      [7:0] rdata_out,
	tuner_link_if.master    link
);
	typedef enum logic [2:0] {IDLE, GAP, SETUP, LOW, HIGH, TAIL} state_type;

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	state_type            st_ff, nxt_st;
	logic [WORD_BITS-1:0] word_ff, nxt_word;
	logic [WORD_BITS-1:0] sh_ff, nxt_sh;
	logic [3:0]           bit_ff, nxt_bit;
	logic [15:0]          cnt_ff, nxt_cnt;
	logic [15:0]          wake_ff, nxt_wake;
	logic                 last_hold_ff, nxt_last_hold;
	logic                 sel_ff, nxt_sel;
	logic                 sck_ff, nxt_sck;
	logic                 sda_ff, nxt_sda;
	logic [7:0]           rdata_ff, nxt_rdata;
	logic                 go;

	assign go = wr_in && addr_in == ADDR_CTRL && wdata_in[CTRL_GO_POS];

	// Bus writes, read data, telegram sequencer
	always_comb begin
		nxt_st        = st_ff;
		nxt_word      = word_ff;
		nxt_sh        = sh_ff;
		nxt_bit       = bit_ff;
		nxt_cnt       = cnt_ff;
		nxt_wake      = (wake_ff != '0) ? wake_ff - 16'd1 : wake_ff;
		nxt_last_hold = last_hold_ff;
		nxt_sel       = sel_ff;
		nxt_sck       = sck_ff;
		nxt_sda       = sda_ff;
		nxt_rdata     = 8'h00;
		if (wr_in && addr_in == ADDR_WORD) begin
			// Top bits forced to zero
			nxt_word = {2'b00, wdata_in[HOLD_BIT_POS:0]};
		end
		if (rd_in) begin
			unique case (addr_in)
				ADDR_WORD:   nxt_rdata = word_ff;
				ADDR_STATUS: nxt_rdata = {6'h00, wake_ff != '0, st_ff != IDLE};
				default:     nxt_rdata = 8'h00;
			endcase
		end
		unique case (st_ff)
			IDLE: if (go) begin
				nxt_sh  = word_ff;
				nxt_bit = 4'(WORD_BITS);
				nxt_cnt = 16'(SEL_LOW_CYC);
				nxt_st  = GAP;
			end
			GAP: begin
				if (cnt_ff > 16'd1) nxt_cnt = cnt_ff - 16'd1;
				else begin
					nxt_sel = 1'b1;
					nxt_cnt = 16'(HALF_CYC);
					nxt_st  = SETUP;
				end
			end
			SETUP, LOW: begin
				if (cnt_ff > 16'd1) nxt_cnt = cnt_ff - 16'd1;
				else begin
					nxt_sck = 1'b1;
					nxt_cnt = 16'(HALF_CYC);
					nxt_bit = bit_ff - 4'd1;
					nxt_st  = HIGH;
				end
				if (st_ff == SETUP && cnt_ff == 16'(HALF_CYC))
					nxt_sda = sh_ff[WORD_BITS-1];
			end
			HIGH: begin
				if (cnt_ff > 16'd1) nxt_cnt = cnt_ff - 16'd1;
				else begin
					nxt_sck = 1'b0;
					nxt_cnt = 16'(HALF_CYC);
					if (bit_ff == 4'd0) nxt_st = TAIL;
					else begin
						nxt_sh  = {sh_ff[WORD_BITS-2:0], 1'b0};
						nxt_sda = sh_ff[WORD_BITS-2];
						nxt_st  = LOW;
					end
				end
			end
			TAIL: begin
				if (cnt_ff > 16'd1) nxt_cnt = cnt_ff - 16'd1;
				else begin
					nxt_sel = 1'b0;
					nxt_sda = 1'b0;
					if (last_hold_ff && !word_ff[HOLD_BIT_POS])
						nxt_wake = 16'(WAKE_CNT);
					nxt_last_hold = word_ff[HOLD_BIT_POS];
					nxt_cnt = 16'(SEL_LOW_CYC);
					nxt_st  = IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_ff        <= IDLE;
			word_ff      <= WORD_RESET;
			sh_ff        <= WORD_RESET;
			bit_ff       <= '0;
			cnt_ff       <= '0;
			wake_ff      <= '0;
			last_hold_ff <= 1'b0;
			sel_ff       <= 1'b0;
			sck_ff       <= 1'b0;
			sda_ff       <= 1'b0;
			rdata_ff     <= 8'h00;
		end else begin
			st_ff        <= nxt_st;
			word_ff      <= nxt_word;
			sh_ff        <= nxt_sh;
			bit_ff       <= nxt_bit;
			cnt_ff       <= nxt_cnt;
			wake_ff      <= nxt_wake;
			last_hold_ff <= nxt_last_hold;
			sel_ff       <= nxt_sel;
			sck_ff       <= nxt_sck;
			sda_ff       <= nxt_sda;
			rdata_ff     <= nxt_rdata;
		end
	end

	assign link.tuner_select   = sel_ff;
	assign link.shift_clk      = sck_ff;
	assign link.shift_data_pin = sda_ff;
	assign rdata_out           = rdata_ff;
endmodule

/* verif/tuner_link_properties.sv */
`timescale 1ns/1ps
module tuner_link_properties (
	input wire logic       core_clk_in,
	input wire logic       arst_n_in,
	input wire logic       tuner_select,
	input wire logic       shift_clk,
	input wire logic       shift_data_pin,
	input wire logic       low_power_hold_out,
	input wire logic [4:0] cap_state_out,
	input wire logic       update_out
);
	// ----
	// Wire shadow and checks
	// ----
	logic [7:0] word_ff;
	logic [7:0] nxt_word;
	logic       clk_q_ff;
	// Shift in on seen rising edges
	always_comb begin
		nxt_word = word_ff;
		if (shift_clk && !clk_q_ff && tuner_select)
			nxt_word = {word_ff[6:0], shift_data_pin};
	end
	// Register the shadow
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			word_ff  <= 8'h00;
			clk_q_ff <= 1'b0;
		end else begin
			word_ff  <= nxt_word;
			clk_q_ff <= shift_clk;
		end
	end
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);
	property p_setup; $rose(tuner_select) |-> !shift_clk [*2]; endproperty
	a_setup: assert property (p_setup)
		else $error("clock too soon after select");
	property p_idle; !tuner_select |-> !shift_clk; endproperty
	a_idle: assert property (p_idle)
		else $error("clock while deselected");
	property p_data; $rose(shift_clk) |-> $stable(shift_data_pin) ##1 $stable(shift_data_pin);
	endproperty
	a_data: assert property (p_data)
		else $error("data moved at rising clock");
	property p_clk_high; $rose(shift_clk) |-> shift_clk [*4] ##1 !shift_clk; endproperty
	a_clk_high: assert property (p_clk_high)
		else $error("clock high phase wrong");
	property p_sel_low; $fell(tuner_select) |-> !tuner_select [*2]; endproperty
	a_sel_low: assert property (p_sel_low)
		else $error("select low too short");
	property p_load;
		$fell(tuner_select) |-> ##[1:6] (update_out && cap_state_out == word_ff[4:0]
			&& low_power_hold_out == word_ff[5]);
	endproperty
	a_load: assert property (p_load)
		else $error("word not loaded");
	property p_change;
		($changed(cap_state_out) || $changed(low_power_hold_out)) |-> update_out;
	endproperty
	a_change: assert property (p_change)
		else $error("outputs moved without load");
	property p_upd; update_out |-> !tuner_select ##1 !update_out; endproperty
	a_upd: assert property (p_upd)
		else $error("load while selected");
endmodule

/* verif/tunable_cap_serial_control_tb_top.sv */
`timescale 1ns/1ps
module tunable_cap_serial_control_tb_top import tuner_link_pkg::*; ;
	typedef struct packed {logic [7:0] w; logic [5:0] e;} row_type;
	row_type rows[5] = '{'{8'h00, 6'h00}, '{8'h1F, 6'h1F}, '{8'hFF, 6'h3F},
		'{8'h25, 6'h25}, '{8'h0A, 6'h0A}};
	logic       core_clk_in = 1'b0;
	logic       arst_n_in = 1'b0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] rdata;
	logic [7:0] d;
	logic       hold1, hold2, upd1, upd2;
	logic [4:0] cap1, cap2;
	logic       hold3, upd3;
	logic [4:0] cap3;
	int         fail_count = 0;
	int         checked = 0;
	tuner_link_if lnk ();
	tuner_link_if lnk2 ();
	tuner_link_if lnk3 ();
	// Third device shares clock and data with the first, own select
	assign lnk3.shift_clk      = lnk.shift_clk;
	assign lnk3.shift_data_pin = lnk.shift_data_pin;
	// Core clock
	always #12.5 core_clk_in = ~core_clk_in;
	tuner_master #(.WAKE_CNT(10)) u_tuner_master (.core_clk_in(core_clk_in),
		.arst_n_in(arst_n_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .link(lnk.master));
	tuner_port u_tuner_port (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
		.link(lnk.tuner), .low_power_hold_out(hold1), .cap_state_out(cap1), .update_out(upd1));
	tuner_port u_tuner_port_b (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
		.link(lnk2.tuner), .low_power_hold_out(hold2), .cap_state_out(cap2), .update_out(upd2));
	tuner_port u_tuner_port_c (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
		.link(lnk3.tuner), .low_power_hold_out(hold3), .cap_state_out(cap3), .update_out(upd3));
	tuner_link_properties u_props (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
		.tuner_select(lnk.tuner_select), .shift_clk(lnk.shift_clk),
		.shift_data_pin(lnk.shift_data_pin), .low_power_hold_out(hold1),
		.cap_state_out(cap1), .update_out(upd1));
	// ----
	// Tasks
	// ----
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
		@(posedge core_clk_in);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge core_clk_in);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [1:0] a);
		@(posedge core_clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk_in);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wait_upd(input bit b);
		int n;
		n = 0;
		do begin
			@(posedge core_clk_in);
			#1 n++;
		end while (!(b ? upd2 : upd1) && n < 400);
		chk({7'h00, (b ? upd2 : upd1)}, 8'h01);
	endtask
	// Hand-made link, 200 ns period, data moves as clock falls
	task automatic bang(input logic [9:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge core_clk_in);
			lnk2.shift_data_pin <= v[i];
			lnk2.shift_clk      <= 1'b0;
			repeat (4) @(posedge core_clk_in);
			lnk2.shift_clk <= 1'b1;
			repeat (3) @(posedge core_clk_in);
		end
		@(posedge core_clk_in);
		lnk2.shift_clk <= 1'b0;
	endtask
	// Select change only; after a fall the load pulse follows within a few cycles
	task automatic sel2(input logic s);
		@(posedge core_clk_in);
		lnk2.tuner_select <= s;
	endtask
	task automatic test_done();
		$display("checks=%0d errors=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (20000) @(posedge core_clk_in);
		fail_count++;
		test_done();
	end
	// Main sequence
	initial begin
		lnk2.tuner_select = 1'b0;
		lnk2.shift_clk = 1'b0;
		lnk2.shift_data_pin = 1'b0;
		lnk3.tuner_select = 1'b0;
		repeat (10) @(posedge core_clk_in);
		arst_n_in <= 1'b1;
		#1 chk({2'b00, hold1, cap1}, 8'h00);
		foreach (rows[i]) begin
			wr_reg(ADDR_WORD, rows[i].w);
			wr_reg(ADDR_CTRL, 8'h01);
			wait_upd(1'b0);
			chk({2'b00, hold1, cap1}, {2'b00, rows[i].e});
		end
		chk({2'b00, hold3, cap3}, 8'h00);
		rd_reg(ADDR_STATUS);
		chk(d, 8'h02);
		repeat (20) @(posedge core_clk_in);
		rd_reg(ADDR_STATUS);
		chk(d, 8'h00);
		wr_reg(ADDR_WORD, 8'h13);
		wr_reg(ADDR_CTRL, 8'h01);
		lnk3.tuner_select <= 1'b1;
		rd_reg(ADDR_STATUS);
		chk(d & 8'h01, 8'h01);
		rd_reg(2'h3);
		chk(d, 8'h00);
		wait_upd(1'b0);
		chk({2'b00, hold1, cap1}, 8'h13);
		chk({2'b00, hold3, cap3}, 8'h00);
		lnk3.tuner_select <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		#1 chk({7'h00, upd3}, 8'h01);
		chk({2'b00, hold3, cap3}, 8'h13);
		rd_reg(ADDR_WORD);
		chk(d, 8'h13);
		wr_reg(ADDR_WORD, 8'hFF);
		rd_reg(ADDR_WORD);
		chk(d, 8'h3F);
		bang(10'h0FF, 8);
		sel2(1'b1);
		bang(10'h005, 4);
		sel2(1'b0);
		wait_upd(1'b1);
		chk({2'b00, hold2, cap2}, 8'h05);
		sel2(1'b1);
		bang(10'h325, 10);
		sel2(1'b0);
		wait_upd(1'b1);
		chk({2'b00, hold2, cap2}, 8'h25);
		chk({2'b00, hold1, cap1}, 8'h13);
		// Reset in mid-run clears both ends
		@(posedge core_clk_in);
		arst_n_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		chk({2'b00, hold2, cap2}, 8'h00);
		chk({2'b00, hold1, cap1}, 8'h00);
		arst_n_in <= 1'b1;
		rd_reg(ADDR_WORD);
		chk(d, 8'h00);
		test_done();
	end
endmodule
